// ---- pkg/mode_list_pkg.sv ----
// Constants and types of the mode parameter list host controller
package mode_list_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int PRM_BYTES = 8;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CMD = 8'h04;
  localparam logic [7:0] OFF_STAT = 8'h08;
  localparam logic [7:0] OFF_MASK = 8'h0C;
  localparam logic [7:0] OFF_SEL_HDR = 8'h10;
  localparam logic [7:0] OFF_SEL_DESC = 8'h14;
  localparam logic [7:0] OFF_SEL_BLEN = 8'h18;
  localparam logic [7:0] OFF_SEL_PAGE = 8'h1C;
  localparam logic [7:0] OFF_SEL_PRM0 = 8'h20;
  localparam logic [7:0] OFF_SEL_PRM1 = 8'h24;
  localparam logic [7:0] OFF_SNS_HDR = 8'h28;
  localparam logic [7:0] OFF_SNS_LEN = 8'h2C;
  localparam logic [7:0] OFF_SNS_DESC = 8'h30;
  localparam logic [7:0] OFF_SNS_BLEN = 8'h34;
  localparam logic [7:0] OFF_SNS_PAGE = 8'h38;
  localparam logic [7:0] OFF_SNS_LEARN = 8'h3C;
  localparam logic [15:0] HDR6_LEN = 16'h0004;
  localparam logic [15:0] HDR10_LEN = 16'h0008;
  localparam logic [15:0] DESC_LEN = 16'h0008;
  localparam logic [15:0] PAGE_HDR_LEN = 16'h0002;
  localparam logic [5:0] PAGE_VENDOR = 6'h00;
  localparam logic [5:0] PAGE_ALL = 6'h3F;
  localparam int SAVABLE_BIT = 7;
  localparam int CTRL_LONG_BIT = 0;
  localparam int CTRL_DESC_BIT = 1;
  localparam int CTRL_ALLPG_BIT = 2;
  localparam int CMD_SENSE_BIT = 0;
  localparam int CMD_SELECT_BIT = 1;
  localparam int ST_SENSE_DONE = 0;
  localparam int ST_SELECT_DONE = 1;
  localparam int ST_LEN_ERR = 2;
  localparam int ST_BDL_ERR = 3;
  localparam int ST_ORDER_ERR = 4;
  localparam int ST_REFUSED = 5;
  localparam int ST_DESC_CHG = 6;
  localparam int ST_W = 7;
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [ST_W-1:0] MASK_RST = 7'h00;
  typedef enum logic [5:0] {
    E_IDLE = 6'b000001,
    E_RX_HDR = 6'b000010,
    E_RX_DESC = 6'b000100,
    E_RX_PGHD = 6'b001000,
    E_RX_PGBODY = 6'b010000,
    E_TX = 6'b100000
  } eng_state_type;
endpackage : mode_list_pkg

// ---- testbench/mode_dev_model.sv ----
// Device side model: sense byte source and select byte sink
`timescale 1ns/1ps
`default_nettype none
module mode_dev_model (
  input wire logic pclk,
  input wire logic slow,
  input wire logic rx_ready,
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic rx_last,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic tx_last,
  output logic tx_ready
);
  logic [7:0] img [0:63];
  logic [7:0] got [0:63];
  int n = 0;
  int i = 0;
  int k = 0;
  int last_at = -1;
  logic ph = 1'b0;
  assign rx_valid = (i < n) && (!slow || ph);
  assign rx_last = (i == n - 1);
  assign rx_data = rx_valid ? img[i] : ~img[(i > 0) ? i - 1 : 0];
  assign tx_ready = !slow || ph;
  always @(posedge pclk) begin
    ph <= ~ph;
    if (rx_valid && rx_ready) i <= i + 1;
    if (tx_valid && tx_ready) begin
      got[k] <= tx_data;
      k <= k + 1;
      if (tx_last) last_at <= k;
    end
  end
endmodule : mode_dev_model
`default_nettype wire

// ---- testbench/mode_list_checker.sv ----
// Port checker of the mode list host
`timescale 1ns/1ps
`default_nettype none
module mode_list_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq,
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  input wire logic rx_last,
  input wire logic rx_ready,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic tx_last,
  input wire logic tx_ready
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_one_cycle_a: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready not one cycle after setup");
  ready_cause_a: assert property (pready |-> $past(psel) && !$past(penable))
    else $error("pready without setup");
  unmapped_err_a: assert property (psel && !penable && paddr > 8'h3C |=> pslverr)
    else $error("no error on unmapped address");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  tx_hold_a: assert property (tx_valid && !tx_ready |=>
    tx_valid && $stable(tx_data) && $stable(tx_last))
    else $error("select byte changed before taken");
  tx_first_zero_a: assert property ($rose(tx_valid) |-> tx_data == 8'h00)
    else $error("select list length byte not zero");
  tx_end_a: assert property (tx_valid && tx_ready && tx_last |=> !tx_valid)
    else $error("select stream runs past last byte");
  rx_stop_a: assert property (rx_valid && rx_ready && rx_last |=> !rx_ready)
    else $error("sense stream still ready after last");
endmodule : mode_list_checker
`default_nettype wire

// ---- testbench/mode_list_host_bench.sv ----
// Self-checking bench of the mode list host
`timescale 1ns/1ps
`default_nettype none
module mode_list_host_bench;
  import mode_list_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic slow = 1'b0;
  logic [31:0] prdata, rv;
  logic pready, pslverr, irq, rx_valid, rx_last, rx_ready, tx_valid, tx_last, tx_ready, ev;
  logic [7:0] rx_data, tx_data;
  int fails = 0;
  int n_tests = 0;
  always #25 pclk = ~pclk;
  mode_list_host mode_list_host_inst (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr, .irq, .rx_data, .rx_valid, .rx_last, .rx_ready,
    .tx_data, .tx_valid, .tx_last, .tx_ready);
  mode_dev_model mode_dev_model_inst (.pclk, .slow, .rx_ready, .rx_data, .rx_valid,
    .rx_last, .tx_data, .tx_valid, .tx_last, .tx_ready);
  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim
  task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] e);
    n_tests++;
    if (seen !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, seen);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Answer is read mid-cycle, so it is the value that stands at the closing edge
    do @(negedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rv, ev);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string s);
    apb(1'b0, a, 32'h0, rv, ev);
    chk(s, rv, e);
  endtask : rd
  task automatic st(input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, OFF_STAT, 32'h0, rv, ev);
    chk("status", rv & m, e);
    wr(OFF_STAT, 32'h7F);
  endtask : st
  task automatic sense(input logic [7:0] q[$]);
    foreach (q[j]) mode_dev_model_inst.img[j] = q[j];
    mode_dev_model_inst.i = 0;
    mode_dev_model_inst.n = q.size();
    wr(OFF_CMD, 32'h1);
    while (mode_dev_model_inst.i < q.size() || rx_ready) @(posedge pclk);
  endtask : sense
  task automatic sel(input logic [7:0] q[$]);
    mode_dev_model_inst.k = 0;
    wr(OFF_CMD, 32'h2);
    while (mode_dev_model_inst.k < q.size()) @(posedge pclk);
    @(posedge pclk);
    foreach (q[j]) chk("select byte", mode_dev_model_inst.got[j], q[j]);
    chk("select last", mode_dev_model_inst.last_at, q.size() - 1);
  endtask : sel
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    end_sim();
  end
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFF_CTRL, 32'h0, "ctrl");
    rd(OFF_MASK, 32'h0, "mask");
    apb(1'b0, 8'h40, 32'h0, rv, ev);
    chk("unmapped", {ev, rv[30:0]}, 32'h8000_0000);
    wr(OFF_SEL_PAGE, 32'h010A);
    sense('{8'h0E, 8'h12, 8'h34, 8'h08, 8'h01, 8'h00, 8'h00, 8'h10, 8'h00, 8'h00, 8'h02,
            8'h00, 8'h8A, 8'h01, 8'h55});
    rd(OFF_SNS_HDR, 32'h0008_3412, "header");
    rd(OFF_SNS_DESC, 32'h0100_0010, "descriptor");
    rd(OFF_SNS_BLEN, 32'h0000_0200, "block length");
    rd(OFF_SNS_LEN, 32'h0000_000E, "data length");
    rd(OFF_SNS_LEARN, 32'h0000_0101, "learned");
    apb(1'b0, OFF_SNS_PAGE, 32'h0, rv, ev);
    chk("page byte", rv & 32'hBF, 32'h8A);
    chk("irq masked", irq, 1'b0);
    wr(OFF_MASK, 32'h1);
    repeat (2) @(posedge pclk);
    chk("irq", irq, 1'b1);
    st(32'h7F, 32'h01);
    repeat (2) @(posedge pclk);
    chk("irq cleared", irq, 1'b0);
    wr(OFF_MASK, 32'h0);
    wr(OFF_CTRL, 32'h1);
    sense('{8'h00, 8'h11, 8'h12, 8'h34, 8'h00, 8'h00, 8'h00, 8'h08, 8'h02, 8'h00, 8'h00,
            8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0A, 8'h01, 8'h55});
    rd(OFF_SNS_BLEN, 32'hC000_0000, "zero flags");
    rd(OFF_SNS_LEN, 32'h0000_0011, "long length");
    st(32'h7F, 32'h41);
    wr(OFF_CTRL, 32'h3);
    wr(OFF_SEL_HDR, 32'h3412);
    wr(OFF_SEL_DESC, 32'h0500_0020);
    wr(OFF_SEL_BLEN, 32'h0000_0200);
    wr(OFF_SEL_PRM0, 32'h0000_0077);
    slow <= 1'b1;
    sel('{8'h00, 8'h00, 8'h12, 8'h34, 8'h00, 8'h00, 8'h00, 8'h08, 8'h05, 8'h00, 8'h00,
          8'h20, 8'h00, 8'h00, 8'h02, 8'h00, 8'h0A, 8'h01, 8'h77});
    slow <= 1'b0;
    wr(OFF_CTRL, 32'h0);
    sel('{8'h00, 8'h12, 8'h34, 8'h00, 8'h0A, 8'h01, 8'h77});
    st(32'h7F, 32'h02);
    wr(OFF_SEL_PAGE, 32'h020A);
    wr(OFF_CMD, 32'h2);
    st(32'h7F, 32'h20);
    wr(OFF_SEL_PAGE, 32'h013F);
    wr(OFF_CMD, 32'h2);
    st(32'h7F, 32'h20);
    chk("no bytes", mode_dev_model_inst.k, 32'd7);
    sense('{8'h09, 8'h12, 8'h34, 8'h00, 8'h0A, 8'h01, 8'h55});
    st(32'h3F, 32'h05);
    wr(OFF_CTRL, 32'h4);
    sense('{8'h09, 8'h12, 8'h34, 8'h00, 8'h00, 8'h01, 8'h66, 8'h0A, 8'h01, 8'h55});
    st(32'h3F, 32'h11);
    sense('{8'h07, 8'h12, 8'h34, 8'h04, 8'h01, 8'h02, 8'h03, 8'h04});
    st(32'h08, 32'h08);
    end_sim();
  end
endmodule : mode_list_host_bench
bind mode_list_host mode_list_checker mode_list_checker_inst (.pclk, .presetn, .paddr, .psel,
  .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .irq, .rx_data, .rx_valid,
  .rx_last, .rx_ready, .tx_data, .tx_valid, .tx_last, .tx_ready);
`default_nettype wire

// ---- verilog/mode_list_host.sv ----
// Host controller that builds mode select lists and parses mode sense data
//
// What this block does
// - Short header: length, medium, device param, descriptor length.
// - Long header: two-byte fields, bytes 4-5 reserved.
// - Sense length excludes itself; zero on select.
// - Descriptor length is eight per descriptor; zero legal.
// - Descriptor: density, 3-byte count, reserved, 3-byte length.
// - Page byte 0: savable flag, reserved, code.
// - Vendor page 00h comes last.
// - Sent page length must equal reported length.
// - Page code decode; 3Fh only on sense.
// - Page length counts only following bytes.
// - List order: header, descriptors, pages.
`timescale 1ns/1ps
`default_nettype none
module mode_list_host (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [mode_list_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [mode_list_pkg::DATA_W-1:0] pwdata,
  output logic [mode_list_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  input wire logic rx_last,
  output logic rx_ready,
  output logic [7:0] tx_data,
  output logic tx_valid,
  output logic tx_last,
  input wire logic tx_ready
);
  import mode_list_pkg::*;

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  logic [2:0] ctrl_q, ctrl_d;
  logic [ST_W-1:0] stat_q, stat_d, mask_q, mask_d, w1c, ev;
  logic [7:0] sel_med_q, sel_med_d, sel_dev_q, sel_dev_d, sel_den_q, sel_den_d;
  logic [23:0] sel_cnt_q, sel_cnt_d, sel_blen_q, sel_blen_d;
  logic [5:0] sel_code_q, sel_code_d;
  logic [7:0] sel_plen_q, sel_plen_d;
  logic [7:0] prm_q [PRM_BYTES];
  logic [7:0] prm_d [PRM_BYTES];
  logic [DATA_W-1:0] prdata_q, prdata_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d, irq_q, irq_d;
  logic wr, setup, cmd_sense, cmd_select;
  // Engine state
  eng_state_type state_q, state_d;
  logic [15:0] idx_q, idx_d, mdl_q, mdl_d, bdl_q, bdl_d, bd_left_q, bd_left_d;
  logic [16:0] total_q, total_d;
  logic [7:0] pg_left_q, pg_left_d;
  logic [7:0] sns_med_q, sns_med_d, sns_dev_q, sns_dev_d, sns_den_q, sns_den_d;
  logic [23:0] sns_cnt_q, sns_cnt_d, sns_blen_q, sns_blen_d;
  logic [5:0] sns_code_q, sns_code_d;
  logic parameters_savable_flag_q, parameters_savable_flag_d;
  logic [7:0] sns_plen_q, sns_plen_d, sns_pnum_q, sns_pnum_d, learn_len_q, learn_len_d;
  logic learn_ok_q, learn_ok_d, prev_vendor_q, prev_vendor_d;
  logic first_q, first_d, desc_seen_q, desc_seen_d;
  logic rx_ready_q, rx_ready_d, tx_valid_q, tx_valid_d, tx_last_q, tx_last_d;
  logic [7:0] tx_data_q, tx_data_d;
  logic acc, chg;
  logic [15:0] hdr_len, desc_len, tx_total, bdl_fin;
  logic [16:0] exp_total;

  assign wr = psel && penable && pwrite && pready_q;
  assign setup = psel && !penable;
  assign cmd_sense = wr && paddr == OFF_CMD && pwdata[CMD_SENSE_BIT];
  assign cmd_select = wr && paddr == OFF_CMD && pwdata[CMD_SELECT_BIT];

  always_comb begin
    ctrl_d = ctrl_q;
    mask_d = mask_q;
    sel_med_d = sel_med_q;
    sel_dev_d = sel_dev_q;
    sel_den_d = sel_den_q;
    sel_cnt_d = sel_cnt_q;
    sel_blen_d = sel_blen_q;
    sel_code_d = sel_code_q;
    sel_plen_d = sel_plen_q;
    prm_d = prm_q;
    prdata_d = prdata_q;
    pready_d = setup;
    pslverr_d = 1'b0;
    if (wr) begin
      case (paddr)
        OFF_CTRL: ctrl_d = pwdata[2:0];
        OFF_MASK: mask_d = pwdata[ST_W-1:0];
        OFF_SEL_HDR: {sel_dev_d, sel_med_d} = pwdata[15:0];
        OFF_SEL_DESC: {sel_den_d, sel_cnt_d} = pwdata;
        OFF_SEL_BLEN: sel_blen_d = pwdata[23:0];
        OFF_SEL_PAGE: {sel_plen_d, sel_code_d} = {pwdata[15:8], pwdata[5:0]};
        default: ;
      endcase
    end
    for (int j = 0; j < PRM_BYTES; j++) begin
      if (wr && paddr == OFF_SEL_PRM0 + 8'(4 * (j / 4))) begin
        prm_d[j] = pwdata[8 * (j % 4) +: 8];
      end
    end
    w1c = (wr && paddr == OFF_STAT) ? pwdata[ST_W-1:0] : '0;
    // Event set wins over clear
    stat_d = (stat_q & ~w1c) | ev;
    irq_d = |(stat_d & mask_d);
    if (setup) begin
      prdata_d = '0;
      case (paddr)
        OFF_CTRL: prdata_d = {29'h0000000, ctrl_q};
        OFF_CMD: prdata_d = {31'h00000000, state_q != E_IDLE};
        OFF_STAT: prdata_d = {25'h0000000, stat_q};
        OFF_MASK: prdata_d = {25'h0000000, mask_q};
        OFF_SEL_HDR: prdata_d = {16'h0000, sel_dev_q, sel_med_q};
        OFF_SEL_DESC: prdata_d = {sel_den_q, sel_cnt_q};
        OFF_SEL_BLEN: prdata_d = {8'h00, sel_blen_q};
        OFF_SEL_PAGE: prdata_d = {16'h0000, sel_plen_q, 2'b00, sel_code_q};
        OFF_SEL_PRM0, OFF_SEL_PRM1: prdata_d = '0;
        OFF_SNS_HDR: prdata_d = {bdl_q, sns_dev_q, sns_med_q};
        OFF_SNS_LEN: prdata_d = {16'h0000, mdl_q};
        OFF_SNS_DESC: prdata_d = {sns_den_q, sns_cnt_q};
        // zero count and zero length flags
        OFF_SNS_BLEN: prdata_d = {sns_cnt_q == 24'h000000, sns_blen_q == 24'h000000,
                                  6'h00, sns_blen_q};
        OFF_SNS_PAGE: prdata_d = {learn_len_q, sns_pnum_q, sns_plen_q,
                                  parameters_savable_flag_q, 1'b0, sns_code_q};
        OFF_SNS_LEARN: prdata_d = {23'h000000, learn_ok_q, learn_len_q};
        default: pslverr_d = 1'b1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RST;
      stat_q <= '0;
      mask_q <= MASK_RST;
      sel_med_q <= '0;
      sel_dev_q <= '0;
      sel_den_q <= '0;
      sel_cnt_q <= '0;
      sel_blen_q <= '0;
      sel_code_q <= '0;
      sel_plen_q <= '0;
      prm_q <= '{default: 8'h00};
      prdata_q <= '0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      sel_med_q <= sel_med_d;
      sel_dev_q <= sel_dev_d;
      sel_den_q <= sel_den_d;
      sel_cnt_q <= sel_cnt_d;
      sel_blen_q <= sel_blen_d;
      sel_code_q <= sel_code_d;
      sel_plen_q <= sel_plen_d;
      prm_q <= prm_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      irq_q <= irq_d;
    end
  end

  // ----------------------------------------
  // Select list byte builder
  // ----------------------------------------
  function automatic logic [7:0] tx_byte(input logic [15:0] i);
    logic [15:0] k;
    k = 16'h0000;
    tx_byte = 8'h00;
    if (i < hdr_len) begin
      if (ctrl_q[CTRL_LONG_BIT]) begin
        case (i[2:0])
          3'h2: tx_byte = sel_med_q;
          3'h3: tx_byte = sel_dev_q;
          3'h7: tx_byte = desc_len[7:0];
          default: tx_byte = 8'h00;
        endcase
      end else begin
        case (i[1:0])
          2'h1: tx_byte = sel_med_q;
          2'h2: tx_byte = sel_dev_q;
          2'h3: tx_byte = desc_len[7:0];
          default: tx_byte = 8'h00;
        endcase
      end
    end else if (i < hdr_len + desc_len) begin
      k = i - hdr_len;
      case (k[2:0])
        3'h0: tx_byte = sel_den_q;
        3'h1: tx_byte = sel_cnt_q[23:16];
        3'h2: tx_byte = sel_cnt_q[15:8];
        3'h3: tx_byte = sel_cnt_q[7:0];
        3'h5: tx_byte = sel_blen_q[23:16];
        3'h6: tx_byte = sel_blen_q[15:8];
        3'h7: tx_byte = sel_blen_q[7:0];
        default: tx_byte = 8'h00;
      endcase
    end else if (i == hdr_len + desc_len) begin
      tx_byte = {2'b00, sel_code_q};
    end else if (i == hdr_len + desc_len + 16'h0001) begin
      tx_byte = sel_plen_q;
    end else begin
      k = i - hdr_len - desc_len - PAGE_HDR_LEN;
      if (k < 16'(PRM_BYTES)) begin
        tx_byte = prm_q[k[$clog2(PRM_BYTES)-1:0]];
      end
    end
  endfunction : tx_byte

  // ----------------------------------------
  // Sense parser and select sender
  // ----------------------------------------
  always_comb begin
    // descriptor length is eight per descriptor
    hdr_len = ctrl_q[CTRL_LONG_BIT] ? HDR10_LEN : HDR6_LEN;
    desc_len = ctrl_q[CTRL_DESC_BIT] ? DESC_LEN : 16'h0000;
    tx_total = hdr_len + desc_len + PAGE_HDR_LEN + {8'h00, sel_plen_q};
    exp_total = {1'b0, mdl_q} + (ctrl_q[CTRL_LONG_BIT] ? 17'h00002 : 17'h00001);
    bdl_fin = ctrl_q[CTRL_LONG_BIT] ? {bdl_q[15:8], rx_data} : {8'h00, rx_data};
    acc = rx_valid && rx_ready_q;
    chg = 1'b0;
    ev = '0;
    state_d = state_q;
    idx_d = idx_q;
    mdl_d = mdl_q;
    bdl_d = bdl_q;
    bd_left_d = bd_left_q;
    total_d = total_q;
    pg_left_d = pg_left_q;
    sns_med_d = sns_med_q;
    sns_dev_d = sns_dev_q;
    sns_den_d = sns_den_q;
    sns_cnt_d = sns_cnt_q;
    sns_blen_d = sns_blen_q;
    sns_code_d = sns_code_q;
    parameters_savable_flag_d = parameters_savable_flag_q;
    sns_plen_d = sns_plen_q;
    sns_pnum_d = sns_pnum_q;
    learn_len_d = learn_len_q;
    learn_ok_d = learn_ok_q;
    prev_vendor_d = prev_vendor_q;
    first_d = first_q;
    desc_seen_d = desc_seen_q;
    rx_ready_d = rx_ready_q;
    tx_valid_d = tx_valid_q;
    tx_last_d = tx_last_q;
    tx_data_d = tx_data_q;
    unique case (state_q)
      E_IDLE: begin
        if (cmd_sense) begin
          state_d = E_RX_HDR;
          {idx_d, mdl_d, bdl_d} = '0;
          total_d = '0;
          sns_pnum_d = '0;
          prev_vendor_d = 1'b0;
          first_d = 1'b1;
          rx_ready_d = 1'b1;
        end else if (cmd_select) begin
          // refuse all-pages code or mismatched length
          if (sel_code_q == PAGE_ALL || sel_plen_q > 8'(PRM_BYTES)
              || (learn_ok_q && learn_len_q != sel_plen_q)) begin
            ev[ST_REFUSED] = 1'b1;
          end else begin
            state_d = E_TX;
            idx_d = '0;
            tx_valid_d = 1'b1;
            tx_data_d = tx_byte(16'h0000);
            tx_last_d = 1'b0;
          end
        end
      end
      E_RX_HDR: begin
        if (acc) begin
          idx_d = idx_q + 16'h0001;
          if (ctrl_q[CTRL_LONG_BIT]) begin
            case (idx_q[2:0])
              3'h0: mdl_d[15:8] = rx_data;
              3'h1: mdl_d[7:0] = rx_data;
              3'h2: sns_med_d = rx_data;
              3'h3: sns_dev_d = rx_data;
              3'h6: bdl_d[15:8] = rx_data;
              3'h7: bdl_d[7:0] = rx_data;
              default: ;
            endcase
          end else begin
            case (idx_q[1:0])
              2'h0: mdl_d = {8'h00, rx_data};
              2'h1: sns_med_d = rx_data;
              2'h2: sns_dev_d = rx_data;
              default: bdl_d = {8'h00, rx_data};
            endcase
          end
          if (idx_q == hdr_len - 16'h0001) begin
            ev[ST_BDL_ERR] = bdl_fin[2:0] != 3'h0;
            idx_d = '0;
            bd_left_d = bdl_fin;
            state_d = (bdl_fin == 16'h0000) ? E_RX_PGHD : E_RX_DESC;
          end
        end
      end
      E_RX_DESC: begin
        if (acc) begin
          idx_d = idx_q + 16'h0001;
          bd_left_d = bd_left_q - 16'h0001;
          if (first_q) begin
            case (idx_q[2:0])
              3'h0: begin chg = rx_data != sns_den_q; sns_den_d = rx_data; end
              3'h1: begin chg = rx_data != sns_cnt_q[23:16]; sns_cnt_d[23:16] = rx_data; end
              3'h2: begin chg = rx_data != sns_cnt_q[15:8]; sns_cnt_d[15:8] = rx_data; end
              3'h3: begin chg = rx_data != sns_cnt_q[7:0]; sns_cnt_d[7:0] = rx_data; end
              3'h5: begin chg = rx_data != sns_blen_q[23:16]; sns_blen_d[23:16] = rx_data; end
              3'h6: begin chg = rx_data != sns_blen_q[15:8]; sns_blen_d[15:8] = rx_data; end
              3'h7: begin chg = rx_data != sns_blen_q[7:0]; sns_blen_d[7:0] = rx_data; end
              default: chg = 1'b0;
            endcase
            ev[ST_DESC_CHG] = chg && desc_seen_q;
            if (idx_q[2:0] == 3'h7) begin
              first_d = 1'b0;
              desc_seen_d = 1'b1;
            end
          end
          if (bd_left_q == 16'h0001) begin
            idx_d = '0;
            state_d = E_RX_PGHD;
          end
        end
      end
      E_RX_PGHD: begin
        if (acc) begin
          idx_d = idx_q + 16'h0001;
          if (idx_q[0] == 1'b0) begin
            sns_code_d = rx_data[5:0];
            parameters_savable_flag_d = rx_data[SAVABLE_BIT];
            sns_pnum_d = sns_pnum_q + 8'h01;
            ev[ST_ORDER_ERR] = ctrl_q[CTRL_ALLPG_BIT] && prev_vendor_q;
            prev_vendor_d = rx_data[5:0] == PAGE_VENDOR;
          end else begin
            sns_plen_d = rx_data;
            if (sns_code_q == sel_code_q) begin
              learn_len_d = rx_data;
              learn_ok_d = 1'b1;
            end
            idx_d = '0;
            pg_left_d = rx_data;
            state_d = (rx_data == 8'h00) ? E_RX_PGHD : E_RX_PGBODY;
          end
        end
      end
      E_RX_PGBODY: begin
        if (acc) begin
          pg_left_d = pg_left_q - 8'h01;
          if (pg_left_q == 8'h01) begin
            state_d = E_RX_PGHD;
          end
        end
      end
      E_TX: begin
        if (tx_valid_q && tx_ready) begin
          if (tx_last_q) begin
            state_d = E_IDLE;
            tx_valid_d = 1'b0;
            tx_last_d = 1'b0;
            ev[ST_SELECT_DONE] = 1'b1;
          end else begin
            idx_d = idx_q + 16'h0001;
            tx_data_d = tx_byte(idx_d);
            tx_last_d = idx_d == tx_total - 16'h0001;
          end
        end
      end
    endcase
    if (acc) begin
      total_d = total_q + 17'h00001;
      if (rx_last) begin
        // received count must match length field
        ev[ST_LEN_ERR] = total_d != exp_total;
        ev[ST_SENSE_DONE] = 1'b1;
        rx_ready_d = 1'b0;
        state_d = E_IDLE;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= E_IDLE;
      {idx_q, mdl_q, bdl_q, bd_left_q} <= '0;
      total_q <= '0;
      pg_left_q <= '0;
      {sns_med_q, sns_dev_q, sns_den_q} <= '0;
      {sns_cnt_q, sns_blen_q} <= '0;
      sns_code_q <= '0;
      parameters_savable_flag_q <= 1'b0;
      {sns_plen_q, sns_pnum_q, learn_len_q} <= '0;
      {learn_ok_q, prev_vendor_q, first_q, desc_seen_q} <= '0;
      {rx_ready_q, tx_valid_q, tx_last_q} <= '0;
      tx_data_q <= '0;
    end else begin
      state_q <= state_d;
      {idx_q, mdl_q, bdl_q, bd_left_q} <= {idx_d, mdl_d, bdl_d, bd_left_d};
      total_q <= total_d;
      pg_left_q <= pg_left_d;
      {sns_med_q, sns_dev_q, sns_den_q} <= {sns_med_d, sns_dev_d, sns_den_d};
      {sns_cnt_q, sns_blen_q} <= {sns_cnt_d, sns_blen_d};
      sns_code_q <= sns_code_d;
      parameters_savable_flag_q <= parameters_savable_flag_d;
      {sns_plen_q, sns_pnum_q, learn_len_q} <= {sns_plen_d, sns_pnum_d, learn_len_d};
      {learn_ok_q, prev_vendor_q, first_q, desc_seen_q} <=
        {learn_ok_d, prev_vendor_d, first_d, desc_seen_d};
      {rx_ready_q, tx_valid_q, tx_last_q} <= {rx_ready_d, tx_valid_d, tx_last_d};
      tx_data_q <= tx_data_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign irq = irq_q;
  assign rx_ready = rx_ready_q;
  assign tx_data = tx_data_q;
  assign tx_valid = tx_valid_q;
  assign tx_last = tx_last_q;
endmodule : mode_list_host
`default_nettype wire
